// file: hw/hsc_pkg.sv
// Purpose: Shared constants and types of the high-side switch channel control
// Assumes: 8-bit frames, write flag first, most significant bit first
// Notes: Bank 1 address 2 holds the hardware configuration register

package hsc_pkg;

    // ************************************************************
    // Sizes
    // ************************************************************
    localparam int HSC_CHANNELS = 6;
    localparam int HSC_LOAD_CHANNELS = 3;
    localparam int HSC_FRAME_BITS = 8;
    localparam logic [3:0] HSC_FRAME_LEN = 4'h8;

    // ************************************************************
    // Register addresses, as {bank, address}
    // ************************************************************
    localparam logic [2:0] HSC_ADR_OUT_LOW = 3'h0;
    localparam logic [2:0] HSC_ADR_OUT_HIGH = 3'h1;
    localparam logic [2:0] HSC_ADR_LOAD_CONFIG = 3'h2;
    localparam logic [2:0] HSC_ADR_SENSE_SELECT = 3'h3;
    localparam logic [2:0] HSC_ADR_HW_CONFIG = 3'h6;

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int HSC_HWC_LOW_BIT = 0;
    localparam int HSC_HWC_RESET_BIT = 1;
    localparam int HSC_HWC_STANDBY_BIT = 1;
    localparam int HSC_LOAD_PWM_BIT = 3;

    // ************************************************************
    // Reset values
    // ************************************************************
    localparam logic [5:0] HSC_OUT_RESET = 6'h00;
    localparam logic [3:0] HSC_LOAD_RESET = 4'h0;
    localparam logic [2:0] HSC_SENSE_STANDBY = 3'h7;
    localparam logic HSC_LOW_BIT_RESET = 1'h0;

    // ************************************************************
    // Frame and pin layouts
    // ************************************************************
    typedef struct packed {
        logic wr;
        logic bank;
        logic [1:0] addr;
        logic [3:0] data;
    } hsc_frame_t;

    typedef struct packed {
        logic sclk;
        logic cs_n;
        logic mosi;
        logic limp;
        logic [5:0] chan_in;
    } hsc_pins_t;

endpackage : hsc_pkg

// file: hw/hsc_pin_sync.sv
// Purpose: Three-stage pin synchroniser with agreement filter
// Assumes: Pins are asynchronous to sys_clk
// Notes: Output changes once stages two and three agree

`timescale 1ns/1ps
`default_nettype none

module hsc_pin_sync
    import hsc_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire hsc_pkg::hsc_pins_t pins,
    output hsc_pkg::hsc_pins_t pins_s
);

    logic [9:0] s1_q;
    logic [9:0] s2_q;
    logic [9:0] s3_q;
    logic [9:0] out_q;
    wire [9:0] agree = ~(s2_q ^ s3_q);
    wire [9:0] out_d = (s3_q & agree) | (out_q & ~agree);

    // Idle levels: chip select high, rest low
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            s1_q <= 10'h100;
            s2_q <= 10'h100;
            s3_q <= 10'h100;
            out_q <= 10'h100;
        end
        else
        begin
            s1_q <= pins;
            s2_q <= s1_q;
            s3_q <= s2_q;
            out_q <= out_d;
        end
    end

    assign pins_s = out_q;

endmodule : hsc_pin_sync

`default_nettype wire

// file: hw/hsc_channel_ctrl.sv
// Purpose: Frame decode, registers and channel switch matrix
// Assumes: Serial mode 0, 8-bit frames, most significant bit first
// Notes: Power stage analog behaviour is outside this block
//
// Summary of operation
// - Frame holds write flag, bank, address, data
// - Writing one to reset bit resets device
// - Standby flag reads one while in standby
// - Six independent switch channels
// - Channel switches from pin or register bit
// - Load type select only for channels 0-2
// - Combining option zero: register OR pin
// - Combining option one: register AND pin
// - Reset command equals power-on register reset
// - First frame after reset: output register, error
// - Limp home resets registers, ignores writes
// - Sense code 111 means standby; other wakes

`timescale 1ns/1ps
`default_nettype none

module hsc_channel_ctrl
    import hsc_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic mosi,
    output logic miso,
    output logic miso_oe,
    input wire logic limp_home_input,
    input wire logic [5:0] channel_input_pin,
    output logic [5:0] channel_power_output,
    output logic [2:0] led_load_select,
    output logic standby_flag,
    output logic transmission_error_flag
);
    import hsc_pkg::*;

    // ************************************************************
    // Pin synchronisation
    // ************************************************************
    hsc_pins_t pins;
    hsc_pins_t pins_s;

    assign pins = '{sclk: sclk, cs_n: cs_n, mosi: mosi,
                    limp: limp_home_input, chan_in: channel_input_pin};

    hsc_pin_sync u_sync (
        .sys_clk(sys_clk),
        .rst(rst),
        .pins(pins),
        .pins_s(pins_s)
    );

    // ************************************************************
    // State
    // ************************************************************
    logic sclk_prev_q;
    logic cs_prev_q;
    logic [7:0] shin_q;
    logic [7:0] shout_q;
    logic [3:0] cnt_q;
    logic err_flag_q;
    logic [2:0] rd_ptr_q;
    logic [5:0] out_reg_q;
    logic [3:0] load_q;
    logic [2:0] sense_q;
    logic low_bit_q;
    logic soft_rst_q;
    logic [5:0] chan_q;

    // ************************************************************
    // Edge and frame decode
    // ************************************************************
    wire sclk_rise = pins_s.sclk & ~sclk_prev_q;
    wire sclk_fall = ~pins_s.sclk & sclk_prev_q;
    wire cs_start = ~pins_s.cs_n & cs_prev_q;
    wire cs_end = pins_s.cs_n & ~cs_prev_q;
    wire frame_ok = cs_end & (cnt_q == HSC_FRAME_LEN);
    wire hsc_frame_t frm = shin_q;
    wire [2:0] frm_adr = {frm.bank, frm.addr};
    wire limp = pins_s.limp;
    wire reg_rst = rst | soft_rst_q | limp;
    wire do_write = frame_ok & frm.wr & ~limp;
    wire wr_out_low = do_write & (frm_adr == HSC_ADR_OUT_LOW);
    wire wr_out_high = do_write & (frm_adr == HSC_ADR_OUT_HIGH);
    wire wr_load = do_write & (frm_adr == HSC_ADR_LOAD_CONFIG);
    wire wr_sense = do_write & (frm_adr == HSC_ADR_SENSE_SELECT);
    wire wr_hwc = do_write & (frm_adr == HSC_ADR_HW_CONFIG);
    wire standby = (sense_q == HSC_SENSE_STANDBY);
    wire pwm_mode = load_q[HSC_LOAD_PWM_BIT];

    // ************************************************************
    // Read data
    // ************************************************************
    logic [3:0] rd_data;
    always_comb
    begin
        unique case (rd_ptr_q)
            HSC_ADR_OUT_LOW: rd_data = out_reg_q[3:0];
            HSC_ADR_OUT_HIGH: rd_data = {2'h0, out_reg_q[5:4]};
            HSC_ADR_LOAD_CONFIG: rd_data = load_q;
            HSC_ADR_SENSE_SELECT: rd_data = {1'h0, sense_q};
            HSC_ADR_HW_CONFIG: rd_data = {2'h0, standby, low_bit_q};
            default: rd_data = 4'h0;
        endcase
    end

    wire [7:0] resp = {err_flag_q, rd_ptr_q, rd_data};

    // ************************************************************
    // Channel matrix
    // ************************************************************
    wire [5:0] chan_reg_mix = pwm_mode ?
        (out_reg_q & pins_s.chan_in) :
        (out_reg_q | pins_s.chan_in);
    wire [5:0] chan_d = limp ? pins_s.chan_in : chan_reg_mix;

    // ************************************************************
    // Serial shift
    // ************************************************************
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            sclk_prev_q <= 1'h0;
            cs_prev_q <= 1'h1;
            shin_q <= 8'h00;
            shout_q <= 8'h00;
            cnt_q <= 4'h0;
            chan_q <= HSC_OUT_RESET;
        end
        else
        begin
            sclk_prev_q <= pins_s.sclk;
            cs_prev_q <= pins_s.cs_n;
            chan_q <= chan_d;
            if (cs_start)
            begin
                shout_q <= resp;
                cnt_q <= 4'h0;
            end
            else if (~pins_s.cs_n && sclk_rise)
            begin
                shin_q <= {shin_q[6:0], pins_s.mosi};
                if (cnt_q != 4'hf)
                begin
                    cnt_q <= cnt_q + 4'h1;
                end
            end
            else if (~pins_s.cs_n && sclk_fall)
            begin
                shout_q <= {shout_q[6:0], 1'h0};
            end
        end
    end

    // ************************************************************
    // Registers
    // ************************************************************
    always_ff @(posedge sys_clk)
    begin
        if (reg_rst)
        begin
            out_reg_q <= HSC_OUT_RESET;
            load_q <= HSC_LOAD_RESET;
            sense_q <= HSC_SENSE_STANDBY;
            low_bit_q <= HSC_LOW_BIT_RESET;
        end
        else
        begin
            if (wr_out_low)
            begin
                out_reg_q[3:0] <= frm.data;
            end
            if (wr_out_high)
            begin
                out_reg_q[5:4] <= frm.data[1:0];
            end
            if (wr_load)
            begin
                load_q <= frm.data;
            end
            if (wr_sense)
            begin
                sense_q <= frm.data[2:0];
            end
            if (wr_hwc)
            begin
                low_bit_q <= frm.data[HSC_HWC_LOW_BIT];
            end
        end
    end

    // ************************************************************
    // Reset command, error flag, read pointer
    // ************************************************************
    always_ff @(posedge sys_clk)
    begin
        if (rst | soft_rst_q)
        begin
            soft_rst_q <= 1'h0;
            err_flag_q <= 1'h1;
            rd_ptr_q <= HSC_ADR_OUT_LOW;
        end
        else
        begin
            soft_rst_q <= wr_hwc & frm.data[HSC_HWC_RESET_BIT];
            if (cs_end)
            begin
                err_flag_q <= ~frame_ok;
            end
            if (frame_ok)
            begin
                rd_ptr_q <= frm_adr;
            end
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    assign miso = shout_q[7];
    assign miso_oe = ~pins_s.cs_n;
    assign channel_power_output = chan_q;
    assign led_load_select = load_q[2:0];
    assign standby_flag = standby;
    assign transmission_error_flag = err_flag_q;

endmodule : hsc_channel_ctrl

`default_nettype wire

// file: bench/hsc_host_model.sv
// Purpose: Serial host model driving frames
// Assumes: Mode 0, msb first
// Notes: Data line inverted while deselected

`timescale 1ns/1ps
`default_nettype none

module hsc_host_model (
    input wire logic sys_clk,
    output logic sclk,
    output logic cs_n,
    output logic mosi,
    input wire logic miso
);
    // ********************************
    // Frame driver
    // ********************************
    initial
    begin
        sclk = 1'b0;
        cs_n = 1'b1;
        mosi = 1'b0;
    end

    // Phases of 6 cycles; n bits sent, fewer than 8 for cut frames
    task automatic frame_n(input logic [7:0] tx, input int n, output logic [7:0] rx);
        cs_n = 1'b0;
        repeat (8) @(negedge sys_clk);
        for (int i = 7; i >= 8 - n; i--)
        begin
            mosi = tx[i];
            repeat (6) @(negedge sys_clk);
            sclk = 1'b1;
            rx[i] = miso;
            repeat (6) @(negedge sys_clk);
            sclk = 1'b0;
        end
        repeat (6) @(negedge sys_clk);
        cs_n = 1'b1;
        mosi = ~mosi;
        repeat (10) @(negedge sys_clk);
    endtask : frame_n

    task automatic frame(input logic [7:0] tx, output logic [7:0] rx);
        frame_n(tx, 8, rx);
    endtask : frame
endmodule : hsc_host_model

`default_nettype wire

// file: bench/hsc_channel_chk.sv
// Purpose: Port assertions of the channel control
// Assumes: Synchronous active-high reset
// Notes: Bound to the channel control

`timescale 1ns/1ps
`default_nettype none

module hsc_channel_chk (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic cs_n,
    input wire logic miso_oe,
    input wire logic limp_home_input,
    input wire logic [5:0] channel_input_pin,
    input wire logic [5:0] channel_power_output,
    input wire logic [2:0] led_load_select,
    input wire logic standby_flag,
    input wire logic transmission_error_flag
);
    // ********************************
    // Assertions
    // ********************************
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);

    sequence s_quiet;
        (cs_n && !limp_home_input)[*8];
    endsequence

    a_reset_vals: assert property ($fell(rst) |-> standby_flag && transmission_error_flag
        && !miso_oe && led_load_select == 3'h0 && channel_power_output == 6'h00)
        else $error("reset values wrong");
    a_oe_idle: assert property (cs_n[*6] |-> !miso_oe)
        else $error("miso enabled while deselected");
    a_oe_active: assert property ((!cs_n)[*6] |-> miso_oe)
        else $error("miso not enabled");
    a_limp_follow: assert property ((limp_home_input && $stable(channel_input_pin))[*8]
        |-> channel_power_output == channel_input_pin)
        else $error("limp outputs differ from pins");
    a_limp_led: assert property (limp_home_input[*8] |-> led_load_select == 3'h0)
        else $error("load type not reset in limp");
    a_led_hold: assert property (s_quiet |-> $stable(led_load_select))
        else $error("load type changed without frame");
    a_standby_hold: assert property (s_quiet |-> $stable(standby_flag))
        else $error("standby changed without frame");
    a_err_hold: assert property (s_quiet |-> $stable(transmission_error_flag))
        else $error("error flag changed without frame");
    a_chan_hold: assert property (s_quiet and $stable(channel_input_pin)[*8]
        |=> $stable(channel_power_output))
        else $error("channel changed without cause");
endmodule : hsc_channel_chk

bind hsc_channel_ctrl hsc_channel_chk u_chk (.sys_clk(sys_clk), .rst(rst), .cs_n(cs_n),
    .miso_oe(miso_oe), .limp_home_input(limp_home_input),
    .channel_input_pin(channel_input_pin), .channel_power_output(channel_power_output),
    .led_load_select(led_load_select), .standby_flag(standby_flag),
    .transmission_error_flag(transmission_error_flag));

`default_nettype wire

// file: bench/test_high_side_switch_channel_control.sv
// Purpose: Self-checking bench of the channel control
// Assumes: Host model drives frames
// Notes: A reply belongs to the previous frame

`timescale 1ns/1ps
`default_nettype none

module test_high_side_switch_channel_control;
    // ********************************
    // Bench
    // ********************************
    logic sys_clk, rst, sclk, cs_n, mosi, miso, miso_oe, limp, sby, err;
    logic [5:0] pins, outs;
    logic [2:0] led;
    logic [7:0] rx;
    int bad_count = 0;
    int n_checks = 0;
    int cycles = 0;

    hsc_channel_ctrl DUT (.sys_clk(sys_clk), .rst(rst), .sclk(sclk), .cs_n(cs_n),
        .mosi(mosi), .miso(miso), .miso_oe(miso_oe), .limp_home_input(limp),
        .channel_input_pin(pins), .channel_power_output(outs), .led_load_select(led),
        .standby_flag(sby), .transmission_error_flag(err));
    hsc_host_model host (.sys_clk(sys_clk), .sclk(sclk), .cs_n(cs_n), .mosi(mosi),
        .miso(miso));

    initial
    begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            bad_count++;
            wrap_up();
        end
    end

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic set_pins(input logic [5:0] v);
        pins = v;
        repeat (10) @(negedge sys_clk);
    endtask : set_pins

    task automatic wrap_up;
        if (bad_count == 0 && n_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : wrap_up

    initial
    begin
        rst = 1'b1;
        limp = 1'b0;
        pins = 6'h00;
        repeat (6) @(negedge sys_clk);
        rst = 1'b0;
        repeat (6) @(negedge sys_clk);
        chk("standby", 8'h01, {7'h0, sby});
        host.frame(8'h00, rx);
        chk("first reply", 8'h80, rx);
        host.frame(8'ha3, rx);
        chk("load type", 8'h03, {5'h0, led});
        host.frame(8'h85, rx);
        chk("load reply", 8'h23, rx);
        set_pins(6'h30);
        chk("or mode", 8'h35, {2'h0, outs});
        host.frame(8'hab, rx);
        chk("out reply", 8'h05, rx);
        set_pins(6'h03);
        chk("and mode", 8'h01, {2'h0, outs});
        host.frame(8'hb3, rx);
        chk("awake", 8'h00, {7'h0, sby});
        host.frame(8'he1, rx);
        host.frame(8'h60, rx);
        chk("config awake", 8'h61, rx);
        host.frame(8'hb7, rx);
        chk("config again", 8'h61, rx);
        chk("standby again", 8'h01, {7'h0, sby});
        host.frame(8'h60, rx);
        chk("sense reply", 8'h37, rx);
        host.frame(8'he2, rx);
        chk("config standby", 8'h63, rx);
        chk("load after cmd", 8'h00, {5'h0, led});
        chk("error after cmd", 8'h01, {7'h0, err});
        chk("out after cmd", 8'h03, {2'h0, outs});
        host.frame(8'h00, rx);
        chk("reply after cmd", 8'h80, rx);
        host.frame_n(8'h8f, 4, rx);
        chk("cut frame error", 8'h01, {7'h0, err});
        chk("cut frame ignored", 8'h03, {2'h0, outs});
        limp = 1'b1;
        host.frame(8'h8f, rx);
        chk("reply after cut", 8'h80, rx);
        set_pins(6'h2a);
        chk("limp out", 8'h2a, {2'h0, outs});
        limp = 1'b0;
        set_pins(6'h00);
        chk("limp write ignored", 8'h00, {2'h0, outs});
        wrap_up();
    end
endmodule : test_high_side_switch_channel_control

`default_nettype wire
